/* File: rtl/phc_port_ctrl.sv */
// Parallel handshake port control: control register, strobe pins, latched port C data,
// port B strobe output and port C drive enables, behind an Avalon-MM slave.
// Assumes strobe and port inputs synchronous to clk; clk stands for the phase-two clock.
`timescale 1ns/1ps

module phc_port_ctrl #(
   parameter int PORT_W = phc_pkg::PORT_W
) (
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   input  wire logic [phc_pkg::ADDR_W-1:0] avs_address,
   input  wire logic                      avs_read,
   input  wire logic                      avs_write,
   input  wire logic [phc_pkg::DATA_W-1:0] avs_writedata,
   input  wire logic [3:0]                avs_byteenable,
   output logic      [phc_pkg::DATA_W-1:0] avs_readdata,
   output logic                           avs_waitrequest,
   input  wire logic                      strobe_input_pin,
   output logic                           strobe_output_pin,
   output logic      [PORT_W-1:0]         port_b_out,
   input  wire logic [PORT_W-1:0]         port_c_in,
   output logic      [PORT_W-1:0]         port_c_out,
   output logic      [PORT_W-1:0]         port_c_oe,
   output logic                           flag_irq
);

   logic [6:0]        cfg_reg,        cfg_next;
   logic              flag_reg,       flag_next;
   logic              arm_reg,        arm_next;
   logic              cap_strobe_reg, cap_strobe_next;
   logic              sync1_reg,      sync1_next;
   logic              sync2_reg,      sync2_next;
   logic              prev_reg,       prev_next;
   logic [PORT_W-1:0] cap_data_reg,   cap_data_next;
   logic [PORT_W-1:0] d1_reg,         d1_next;
   logic [PORT_W-1:0] d2_reg,         d2_next;
   logic [PORT_W-1:0] latch_reg,      latch_next;
   logic [PORT_W-1:0] port_b_reg,     port_b_next;
   logic [PORT_W-1:0] port_c_reg,     port_c_next;
   logic [PORT_W-1:0] port_c_direction_bits_reg,       port_c_direction_bits_next;
   logic              strobe_output_pin_q_reg,     strobe_output_pin_q_next;
   logic [1:0]        pulse_cnt_reg,  pulse_cnt_next;
   logic              ack_reg,        ack_next;
   logic [31:0]       rdata_reg,      rdata_next;

   phc_pkg::phc_mode_type mode;
   logic              req;
   logic              fire_rd;
   logic              fire_wr;
   logic              wr_low;
   logic              hit_ctrl;
   logic              hit_portc;
   logic              hit_portb;
   logic              hit_latch;
   logic              hit_port_c_direction_bits;
   logic              edge_sel;
   logic              edge_det;
   logic              pulse_eff;
   logic              strobe_output_pin_set;
   logic              strobe_output_pin_clr;
   logic              clr_access;
   logic              tri_force;
   logic [PORT_W-1:0] rd_mux;

   assign req       = avs_read | avs_write;
   assign fire_rd   = avs_read & ack_reg;
   assign fire_wr   = avs_write & ack_reg;
   assign wr_low    = fire_wr & avs_byteenable[0];
   assign hit_ctrl  = (avs_address == phc_pkg::CTRL_ADDR);
   assign hit_portc = (avs_address == phc_pkg::PORTC_ADDR);
   assign hit_portb = (avs_address == phc_pkg::PORTB_ADDR);
   assign hit_latch = (avs_address == phc_pkg::LATCH_ADDR);
   assign hit_port_c_direction_bits  = (avs_address == phc_pkg::PORT_C_DIRECTION_BITS_ADDR);
   // One wait cycle per access; the second edge completes it
   assign avs_waitrequest = req & ~ack_reg;
   assign avs_readdata    = rdata_reg;

   // Mode decode; direction bit only counts with handshake on
   always_comb begin
      if (!cfg_reg[phc_pkg::HS_BIT]) begin
         mode = phc_pkg::PHC_SIMPLE;
      end else if (cfg_reg[phc_pkg::DIR_BIT]) begin
         mode = phc_pkg::PHC_OUT_HS;
      end else begin
         mode = phc_pkg::PHC_IN_HS;
      end
   end

   assign edge_sel = cfg_reg[phc_pkg::EDGE_BIT];
   // Edge seen only after the synchroniser, so every event is one clean cycle
   assign edge_det = edge_sel ? (sync2_reg & ~prev_reg) : (~sync2_reg & prev_reg);
   assign pulse_eff = (mode == phc_pkg::PHC_SIMPLE) | cfg_reg[phc_pkg::PLS_BIT];

   always_comb begin
      strobe_output_pin_set   = 1'b0;
      clr_access = 1'b0;
      case (mode)
         phc_pkg::PHC_SIMPLE: begin
            strobe_output_pin_set   = wr_low & hit_portb;
            clr_access = fire_rd & hit_latch;
         end
         phc_pkg::PHC_IN_HS: begin
            strobe_output_pin_set   = fire_rd & hit_latch;
            clr_access = fire_rd & hit_latch;
         end
         phc_pkg::PHC_OUT_HS: begin
            strobe_output_pin_set   = wr_low & hit_latch;
            clr_access = wr_low & hit_latch;
         end
         default: begin
            strobe_output_pin_set   = 1'b0;
            clr_access = 1'b0;
         end
      endcase
   end

   // Pulsed negation after two cycles; in handshake modes the acknowledge edge negates too
   assign strobe_output_pin_clr = (strobe_output_pin_q_reg & pulse_eff & (pulse_cnt_reg == phc_pkg::PULSE_LAST))
                   | (edge_det & (mode != phc_pkg::PHC_SIMPLE));

   always_comb begin
      case (avs_address)
         phc_pkg::CTRL_ADDR:  rd_mux = {flag_reg, cfg_reg};
         phc_pkg::PORTC_ADDR: rd_mux = port_c_in;
         phc_pkg::PORTB_ADDR: rd_mux = port_b_reg;
         phc_pkg::LATCH_ADDR: rd_mux = latch_reg;
         phc_pkg::PORT_C_DIRECTION_BITS_ADDR:  rd_mux = port_c_direction_bits_reg;
         default:             rd_mux = phc_pkg::PORT_RESET;
      endcase
   end

   always_comb begin
      cfg_next        = cfg_reg;
      flag_next       = flag_reg;
      arm_next        = arm_reg;
      cap_strobe_next = strobe_input_pin;
      sync1_next      = cap_strobe_reg;
      sync2_next      = sync1_reg;
      prev_next       = sync2_reg;
      cap_data_next   = port_c_in;
      d1_next         = cap_data_reg;
      d2_next         = d1_reg;
      latch_next      = latch_reg;
      port_b_next     = port_b_reg;
      port_c_next     = port_c_reg;
      port_c_direction_bits_next       = port_c_direction_bits_reg;
      strobe_output_pin_q_next     = strobe_output_pin_q_reg;
      pulse_cnt_next  = pulse_cnt_reg;
      ack_next        = req & ~ack_reg;
      rdata_next      = rdata_reg;
      if (avs_read && !ack_reg) begin
         rdata_next = {24'h00_0000, rd_mux};
      end
      if (wr_low) begin
         if (hit_ctrl) begin
            cfg_next = avs_writedata[6:0];
         end
         if (hit_portb) begin
            port_b_next = avs_writedata[PORT_W-1:0];
         end
         if (hit_port_c_direction_bits) begin
            port_c_direction_bits_next = avs_writedata[PORT_W-1:0];
         end
         if (hit_portc || (hit_latch && mode == phc_pkg::PHC_OUT_HS)) begin
            port_c_next = avs_writedata[PORT_W-1:0];
         end
      end
      // Flag clear on an armed access; a fresh edge in the same cycle wins
      if (arm_reg && clr_access) begin
         flag_next = 1'b0;
         arm_next  = 1'b0;
      end
      if (fire_rd && hit_ctrl && flag_reg) begin
         arm_next = 1'b1;
      end
      if (edge_det) begin
         latch_next = d2_reg;
         flag_next  = 1'b1;
         arm_next   = 1'b0;
      end
      // Set/reset flop; a new assertion restarts the pulse and wins over negation
      if (strobe_output_pin_q_reg) begin
         pulse_cnt_next = pulse_cnt_reg + 2'h1;
      end
      if (strobe_output_pin_clr) begin
         strobe_output_pin_q_next = 1'b0;
      end
      if (strobe_output_pin_set) begin
         strobe_output_pin_q_next    = 1'b1;
         pulse_cnt_next = 2'h0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cfg_reg        <= phc_pkg::CFG_RESET;
         flag_reg       <= 1'b0;
         arm_reg        <= 1'b0;
         cap_strobe_reg <= 1'b0;
         sync1_reg      <= 1'b0;
         sync2_reg      <= 1'b0;
         prev_reg       <= 1'b0;
         cap_data_reg   <= phc_pkg::PORT_RESET;
         d1_reg         <= phc_pkg::PORT_RESET;
         d2_reg         <= phc_pkg::PORT_RESET;
         latch_reg      <= phc_pkg::PORT_RESET;
         port_b_reg     <= phc_pkg::PORT_RESET;
         port_c_reg     <= phc_pkg::PORT_RESET;
         port_c_direction_bits_reg       <= phc_pkg::PORT_RESET;
         strobe_output_pin_q_reg     <= 1'b0;
         pulse_cnt_reg  <= 2'h0;
         ack_reg        <= 1'b0;
         rdata_reg      <= 32'h0000_0000;
      end else begin
         cfg_reg        <= cfg_next;
         flag_reg       <= flag_next;
         arm_reg        <= arm_next;
         cap_strobe_reg <= cap_strobe_next;
         sync1_reg      <= sync1_next;
         sync2_reg      <= sync2_next;
         prev_reg       <= prev_next;
         cap_data_reg   <= cap_data_next;
         d1_reg         <= d1_next;
         d2_reg         <= d2_next;
         latch_reg      <= latch_next;
         port_b_reg     <= port_b_next;
         port_c_reg     <= port_c_next;
         port_c_direction_bits_reg       <= port_c_direction_bits_next;
         strobe_output_pin_q_reg     <= strobe_output_pin_q_next;
         pulse_cnt_reg  <= pulse_cnt_next;
         ack_reg        <= ack_next;
         rdata_reg      <= rdata_next;
      end
   end

   // Polarity only picks the flop side, so flipping it never moves the handshake
   assign strobe_output_pin = cfg_reg[phc_pkg::POL_BIT] ? strobe_output_pin_q_reg : ~strobe_output_pin_q_reg;
   assign flag_irq          = flag_reg & cfg_reg[phc_pkg::IRQE_BIT];
   assign port_b_out        = port_b_reg;
   assign port_c_out        = port_c_reg;
   // Uses the captured pin level; the enable lags the pin by one cycle
   assign tri_force = (mode == phc_pkg::PHC_OUT_HS) & (edge_sel ^ cap_strobe_reg);

   generate
      for (genvar i = 0; i < PORT_W; i++) begin : g_pc_drive
         // Open-drain: a high bit releases the pin instead of driving it
         assign port_c_oe[i] = (port_c_direction_bits_reg[i] | tri_force)
                             & ~(cfg_reg[phc_pkg::OD_BIT] & port_c_reg[i]);
      end
   endgenerate

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_armed_clear;
      arm_reg && clr_access && !edge_det;
   endsequence

   sequence s_pulse_two;
      strobe_output_pin_q_reg ##1 (!strobe_output_pin_q_reg || $past(strobe_output_pin_set));
   endsequence

   sequence s_ack_edge;
      strobe_output_pin_q_reg && edge_det && (mode != phc_pkg::PHC_SIMPLE) && !strobe_output_pin_set;
   endsequence

   sequence s_ready_idle;
      (mode == phc_pkg::PHC_IN_HS) && !strobe_output_pin_q_reg && !(fire_rd && hit_latch);
   endsequence

   flag_set_a: assert property (edge_det |=> flag_reg)
      else $error("edge did not set flag");
   disarm_edge_a: assert property (edge_det |=> !arm_reg)
      else $error("edge did not disarm clearing");
   arm_read_a: assert property ((fire_rd && hit_ctrl && flag_reg && !edge_det) |=> arm_reg)
      else $error("control read did not arm");
   flag_clear_a: assert property (s_armed_clear |=> !flag_reg)
      else $error("armed access did not clear flag");
   pulse_len_a: assert property (($rose(strobe_output_pin_q_reg) && pulse_eff && !strobe_output_pin_set) |=> s_pulse_two)
      else $error("strobe pulse not two cycles");
   interlock_hold_a: assert property ((strobe_output_pin_q_reg && !pulse_eff && !edge_det) |=> strobe_output_pin_q_reg)
      else $error("interlocked strobe dropped early");
   simple_pulse_a: assert property ((mode == phc_pkg::PHC_SIMPLE && wr_low && hit_portb)
      |=> strobe_output_pin_q_reg ##1 strobe_output_pin_q_reg)
      else $error("port B write gave no strobe");
   ready_read_a: assert property ((mode == phc_pkg::PHC_IN_HS && fire_rd && hit_latch)
      |=> strobe_output_pin_q_reg)
      else $error("latch read did not assert ready");
   tri_drive_a: assert property ((tri_force && !cfg_reg[phc_pkg::OD_BIT]) |-> (&port_c_oe))
      else $error("port C not forced to drive");
   irq_follow_a: assert property (($rose(flag_reg) && cfg_reg[phc_pkg::IRQE_BIT]) |-> flag_irq)
      else $error("flag raised no interrupt");
   bus_wait_a: assert property ((req && !ack_reg) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("access not answered in one wait cycle");

   // Flag, arming and latch
   flag_source_a: assert property ((!flag_reg && !edge_det)
      |=> !flag_reg)
      else $error("flag set without selected edge");
   flag_hold_a: assert property ((flag_reg && !arm_reg)
      |=> flag_reg)
      else $error("unarmed flag cleared");
   arm_drop_a: assert property (s_armed_clear
      |=> !arm_reg)
      else $error("clearing access left arming set");
   latch_hold_a: assert property (!edge_det
      |=> $stable(latch_reg))
      else $error("latch changed without edge");
   write_keep_a: assert property ((mode != phc_pkg::PHC_OUT_HS && flag_reg && fire_wr
      && !avs_read && hit_latch) |=> flag_reg)
      else $error("latch write cleared flag in read-clear mode");
   edge_single_a: assert property ((edge_det && !(wr_low && hit_ctrl))
      |=> !edge_det)
      else $error("edge event longer than one cycle");
   irq_mask_a: assert property (!cfg_reg[phc_pkg::IRQE_BIT]
      |-> !flag_irq)
      else $error("masked flag raised interrupt");

   // Strobe output
   // Set beats clear in the flop, so each check excludes a same-cycle set
   portb_plain_a: assert property ((mode != phc_pkg::PHC_SIMPLE && wr_low && hit_portb
      && !strobe_output_pin_q_reg) |=> !strobe_output_pin_q_reg)
      else $error("port B write strobed in handshake mode");
   ready_idle_a: assert property (s_ready_idle
      |=> !strobe_output_pin_q_reg)
      else $error("ready asserted without latch read");
   ack_negate_a: assert property (s_ack_edge
      |=> !strobe_output_pin_q_reg)
      else $error("acknowledge edge left strobe asserted");
   pulse_stop_a: assert property ((strobe_output_pin_q_reg && pulse_eff && !strobe_output_pin_set
      && pulse_cnt_reg == phc_pkg::PULSE_LAST) |=> !strobe_output_pin_q_reg)
      else $error("pulsed strobe overran");
   pol_keep_a: assert property ((wr_low && hit_ctrl && !strobe_output_pin_set && !strobe_output_pin_clr)
      |=> $stable(strobe_output_pin_q_reg))
      else $error("control write disturbed strobe flop");

   // Port C data and drive
   // Force follows the captured pin, one cycle behind the pin itself
   out_data_a: assert property ((mode == phc_pkg::PHC_OUT_HS && wr_low && hit_latch)
      |=> (port_c_out == PORT_W'($past(avs_writedata))))
      else $error("latch write did not reach port C");
   latch_write_a: assert property ((mode != phc_pkg::PHC_OUT_HS && wr_low && hit_latch)
      |=> $stable(port_c_out))
      else $error("latch write moved port C outside output handshake");
   od_release_a: assert property (cfg_reg[phc_pkg::OD_BIT]
      |-> ((port_c_oe & port_c_out) == {PORT_W{1'b0}}))
      else $error("open-drain pin driven high");
   dir_follow_a: assert property (!tri_force
      |-> ((port_c_oe & ~port_c_direction_bits_reg) == {PORT_W{1'b0}}))
      else $error("input pin driven without force");

endmodule : phc_port_ctrl

/* File: rtl/phc_pkg.sv */
// Constants, register map and mode type for the parallel handshake port control.
// Assumes an Avalon-MM master with byte addresses and a 32-bit data bus.
package phc_pkg;
   localparam int          ADDR_W         = 16;
   localparam int          DATA_W         = 32;
   localparam int          PORT_W         = 8;
   // Printed offsets are register indices; the byte address is four times the index
   localparam int          CTRL_IDX       = 32'h0000_1002;
   localparam int          PORTC_IDX      = 32'h0000_1003;
   localparam int          PORTB_IDX      = 32'h0000_1004;
   localparam int          LATCH_IDX      = 32'h0000_1005;
   localparam int          PORT_C_DIRECTION_BITS_IDX       = 32'h0000_1007;
   localparam logic [15:0] CTRL_ADDR      = 16'(CTRL_IDX * 4);
   localparam logic [15:0] PORTC_ADDR     = 16'(PORTC_IDX * 4);
   localparam logic [15:0] PORTB_ADDR     = 16'(PORTB_IDX * 4);
   localparam logic [15:0] LATCH_ADDR     = 16'(LATCH_IDX * 4);
   localparam logic [15:0] PORT_C_DIRECTION_BITS_ADDR      = 16'(PORT_C_DIRECTION_BITS_IDX * 4);
   // Control register fields
   localparam int          FLAG_BIT       = 7;
   localparam int          IRQE_BIT       = 6;
   localparam int          OD_BIT         = 5;
   localparam int          HS_BIT         = 4;
   localparam int          DIR_BIT        = 3;
   localparam int          PLS_BIT        = 2;
   localparam int          EDGE_BIT       = 1;
   localparam int          POL_BIT        = 0;
   // Undefined pulse-mode bit comes up clear; edge and polarity bits set
   localparam logic [6:0]  CFG_RESET      = 7'h03;
   localparam logic [7:0]  PORT_RESET     = 8'h00;
   // Strobe pulse length in E-clock cycles; the E clock is clk here
   localparam int          PULSE_E_CYCLES = 2;
   localparam logic [1:0]  PULSE_LAST     = 2'(PULSE_E_CYCLES - 1);

   typedef enum logic [1:0] {
      PHC_SIMPLE,
      PHC_IN_HS,
      PHC_OUT_HS
   } phc_mode_type;
endpackage : phc_pkg

/* File: sim/phc_partner.sv */
// External system model: strobes bytes into port C, acknowledges output bytes.
// Assumes the bench raises go for one cycle per strobe pulse.
`timescale 1ns/1ps
module phc_partner (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       go,
   input  wire logic       edge_sel,
   input  wire logic [7:0] data,
   input  wire logic [7:0] port_c_out,
   input  wire logic [7:0] port_c_oe,
   output logic            strobe_input_pin,
   output logic      [7:0] port_c_in
);
   logic [2:0] cnt_reg;
   logic       hold_reg;
   logic [7:0] noise_reg;
   logic [7:0] ext;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_reg   <= 3'h0;
         hold_reg  <= 1'b0;
         noise_reg <= 8'h00;
      end else begin
         noise_reg <= noise_reg + 8'h3B;
         hold_reg  <= (cnt_reg == 3'h1);
         if (go && cnt_reg == 3'h0) cnt_reg <= 3'h4;
         else if (cnt_reg != 3'h0) cnt_reg <= cnt_reg - 3'h1;
      end
   end
   // Pulse to the inactive level, end on the active edge
   assign strobe_input_pin = (cnt_reg != 3'h0) ? ~edge_sel : edge_sel;
   // Data held one cycle past the edge; otherwise a changing pattern
   assign ext       = (cnt_reg != 3'h0 || hold_reg) ? data : noise_reg;
   assign port_c_in = (port_c_oe & port_c_out) | (~port_c_oe & ext);
endmodule : phc_partner

/* File: sim/tb.sv */
// Self-checking bench for the parallel handshake port control.
// Assumes Avalon-MM access with one wait cycle and a partner on the strobe pins.
`timescale 1ns/1ps
module tb;
   logic        clk, rst_n, avs_read, avs_write, go, edge_sel, avs_waitrequest;
   logic        strobe_input_pin, strobe_output_pin, flag_irq;
   logic [15:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0]  avs_byteenable;
   logic [7:0]  port_b_out, port_c_in, port_c_out, port_c_oe, pdata;
   int          mismatches, samples_checked, n;
   phc_port_ctrl i_phc_port_ctrl (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .strobe_input_pin(strobe_input_pin),
      .strobe_output_pin(strobe_output_pin), .port_b_out(port_b_out), .port_c_in(port_c_in),
      .port_c_out(port_c_out), .port_c_oe(port_c_oe), .flag_irq(flag_irq));
   phc_partner i_phc_partner (.clk(clk), .rst_n(rst_n), .go(go), .edge_sel(edge_sel), .data(pdata),
      .port_c_out(port_c_out), .port_c_oe(port_c_oe), .strobe_input_pin(strobe_input_pin),
      .port_c_in(port_c_in));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
      int k;
      @(posedge clk);
      avs_address   <= a;
      avs_writedata <= {24'h0, d};
      avs_read      <= !w;
      avs_write     <= w;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 50);
      if (k >= 50) begin
         mismatches++;
         $display("mismatch waitrequest expected 0 seen 1");
      end
      q = avs_readdata[7:0];
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      // Let the launching edge settle before callers look at outputs
      @(negedge clk);
   endtask : bus
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic rdc(input logic [15:0] a, input logic [7:0] e, input string nm);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(nm, e, q);
   endtask : rdc
   task automatic pulse(input logic [7:0] d);
      @(posedge clk);
      pdata <= d;
      go    <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (12) @(posedge clk);
   endtask : pulse
   // Cycles with the strobe output high over the next ten edges
   task automatic high_cnt(input logic [7:0] e, input string nm);
      n = 0;
      repeat (10) begin
         @(posedge clk);
         if (strobe_output_pin === 1'b1) n++;
      end
      chk(nm, e, 8'(n));
   endtask : high_cnt
   task automatic t_simple();
      rdc(phc_pkg::CTRL_ADDR, 8'h03, "ctrl reset");
      rdc(16'h0000, 8'h00, "unmapped");
      wr(phc_pkg::CTRL_ADDR, 8'h01);
      wr(phc_pkg::PORTB_ADDR, 8'h5A);
      chk("port b", 8'h5A, port_b_out);
      high_cnt(8'h02, "simple pulse");
      wr(phc_pkg::CTRL_ADDR, 8'h05);
      wr(phc_pkg::PORTB_ADDR, 8'hA6);
      high_cnt(8'h02, "simple pulse pls");
      wr(phc_pkg::CTRL_ADDR, 8'h00);
      @(posedge clk);
      chk("inverted idle", 8'h01, {7'h0, strobe_output_pin});
      wr(phc_pkg::CTRL_ADDR, 8'h01);
      $display("test simple done");
   endtask : t_simple
   task automatic t_latch();
      pulse(8'hC3);
      rdc(phc_pkg::CTRL_ADDR, 8'h81, "flag set");
      chk("irq masked", 8'h00, {7'h0, flag_irq});
      wr(phc_pkg::CTRL_ADDR, 8'h41);
      chk("irq on", 8'h01, {7'h0, flag_irq});
      rdc(phc_pkg::LATCH_ADDR, 8'hC3, "latch");
      rdc(phc_pkg::CTRL_ADDR, 8'h41, "flag clear");
      chk("irq off", 8'h00, {7'h0, flag_irq});
      wr(phc_pkg::CTRL_ADDR, 8'h01);
      pulse(8'h3C);
      rdc(phc_pkg::CTRL_ADDR, 8'h81, "arm");
      pulse(8'h96);
      rdc(phc_pkg::LATCH_ADDR, 8'h96, "latch 2");
      rdc(phc_pkg::CTRL_ADDR, 8'h81, "disarmed");
      rdc(phc_pkg::LATCH_ADDR, 8'h96, "latch 3");
      rdc(phc_pkg::CTRL_ADDR, 8'h01, "cleared");
      $display("test latch done");
   endtask : t_latch
   task automatic t_in_hs();
      wr(phc_pkg::CTRL_ADDR, 8'h11);
      repeat (6) @(posedge clk);
      chk("ready idle", 8'h00, {7'h0, strobe_output_pin});
      wr(phc_pkg::PORTB_ADDR, 8'h77);
      high_cnt(8'h00, "no port b strobe");
      rdc(phc_pkg::LATCH_ADDR, 8'h96, "latch read");
      high_cnt(8'h0A, "interlocked");
      pulse(8'hE1);
      chk("ready negated", 8'h00, {7'h0, strobe_output_pin});
      rdc(phc_pkg::CTRL_ADDR, 8'h91, "in flag");
      rdc(phc_pkg::LATCH_ADDR, 8'hE1, "in latch");
      chk("ready again", 8'h01, {7'h0, strobe_output_pin});
      pulse(8'h5F);
      wr(phc_pkg::CTRL_ADDR, 8'h15);
      rdc(phc_pkg::LATCH_ADDR, 8'h5F, "pulsed read");
      high_cnt(8'h02, "pulsed ready");
      $display("test input handshake done");
   endtask : t_in_hs
   task automatic t_out_hs();
      rdc(phc_pkg::CTRL_ADDR, 8'h95, "arm out");
      wr(phc_pkg::CTRL_ADDR, 8'h19);
      wr(phc_pkg::LATCH_ADDR, 8'hA5);
      chk("port c out", 8'hA5, port_c_out);
      chk("out strobe", 8'h01, {7'h0, strobe_output_pin});
      rdc(phc_pkg::CTRL_ADDR, 8'h19, "out clear");
      chk("oe idle", 8'h00, port_c_oe);
      @(posedge clk);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (2) @(posedge clk);
      chk("oe forced", 8'hFF, port_c_oe);
      repeat (10) @(posedge clk);
      chk("oe released", 8'h00, port_c_oe);
      chk("out ack", 8'h00, {7'h0, strobe_output_pin});
      rdc(phc_pkg::CTRL_ADDR, 8'h99, "out flag");
      wr(phc_pkg::PORT_C_DIRECTION_BITS_ADDR, 8'hFF);
      wr(phc_pkg::CTRL_ADDR, 8'h39);
      chk("open drain", 8'h5A, port_c_oe);
      $display("test output handshake done");
   endtask : t_out_hs
   task automatic t_rise();
      wr(phc_pkg::CTRL_ADDR, 8'h01);
      wr(phc_pkg::PORT_C_DIRECTION_BITS_ADDR, 8'h00);
      wr(phc_pkg::LATCH_ADDR, 8'h11);
      chk("latch write ignored", 8'hA5, port_c_out);
      rdc(phc_pkg::LATCH_ADDR, 8'hA5, "out latch");
      @(posedge clk);
      edge_sel <= 1'b1;
      repeat (6) @(posedge clk);
      rdc(phc_pkg::CTRL_ADDR, 8'h01, "rise ignored");
      wr(phc_pkg::CTRL_ADDR, 8'h03);
      pulse(8'h69);
      rdc(phc_pkg::CTRL_ADDR, 8'h83, "rise flag");
      rdc(phc_pkg::LATCH_ADDR, 8'h69, "rise latch");
      $display("test rising edge done");
   endtask : t_rise
   initial begin
      rst_n          <= 1'b0;
      avs_read       <= 1'b0;
      avs_write      <= 1'b0;
      avs_address    <= 16'h0000;
      avs_writedata  <= 32'h0000_0000;
      avs_byteenable <= 4'h1;
      go             <= 1'b0;
      edge_sel       <= 1'b0;
      pdata          <= 8'h00;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_simple();
      t_latch();
      t_in_hs();
      t_out_hs();
      t_rise();
      report_and_stop();
   end
   // Whole run needs under four hundred cycles
   initial begin
      #(8 * 20000);
      mismatches++;
      $display("mismatch watchdog expected finish seen timeout");
      report_and_stop();
   end
endmodule : tb
